// file: lsbbm_regs.sv
// register slice with ahb-lite slave, direct switch control and break-before-make sequencer
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RQ1] The low byte of channel 3's ten-bit current code is an eight-bit read/write register reset to zero.
// [RQ2] Bits 9 and 8 of that code come from bits 1 and 0 of the preceding register; its upper bits are kept as is.
// [RQ3] Every code from zero to the ten-bit maximum is passed to the current output unchanged.
// [RQ4] With direct control on, switch-control bits 7, 6 and 5 drive channel 3, 2 and 1 switches.
// [RQ5] With direct control off, those bits are stored but do not affect any switch.
// [RQ6] The analog mux register holds enable, calibration disable, two-bit gain and four-bit input select, reset zero.
// [RQ7] The eight-bit dead-time code gives zero delay for code 0, 333 ns for code 1 and 111 ns more per step.
// [RQ8] After the colour select input changes, the active switches turn off within 333 to 444 ns.
module lsbbm_regs
   import lsbbm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [1:0] colour_channel_select,
   output logic [9:0] channel3_current_code,
   output logic [2:0] channel_switch_on,
   output logic [4:0] undervoltage_trim,
   output logic analog_mux_enable,
   output logic analog_calibration_disable,
   output logic [1:0] analog_gain_select,
   output logic [3:0] analog_input_select
);

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // select 1..3 picks channel 1..3; 0 leaves all off
   function automatic logic [2:0] sel_decode(input logic [1:0] sel);
      logic [2:0] m;
      m = 3'h0;
      if (sel != 2'h0) begin
         m[sel - 2'h1] = 1'b1;
      end
      return m;
   endfunction

   // least time, so round up
   function automatic logic [CNT_W-1:0] dead_cycles(input logic [7:0] code);
      int ns;
      ns = 0;
      if (code != 8'h00) begin
         ns = BBM_FIRST_NS + BBM_STEP_NS * (int'(code) - 1);
      end
      return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction

   // ---------------------------------------------
   // bus slave
   // ---------------------------------------------
   logic dp_wr_r;
   logic [ADDR_W-1:0] dp_addr_r;
   logic [31:0] hrdata_r;
   logic [7:0] ch3_hi_r, ch3_lo_r, sw_ctrl_r, amux_r, bbm_r, mode_r;
   logic [7:0] ch3_hi_nxt, ch3_lo_nxt, sw_ctrl_nxt, amux_nxt, bbm_nxt, mode_nxt;
   wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ);
   wire logic [ADDR_W-1:0] a_addr = haddr[ADDR_W-1:0];
   wire logic we_hi = dp_wr_r && (dp_addr_r == ADDR_CH3_HI);
   wire logic we_lo = dp_wr_r && (dp_addr_r == ADDR_CH3_LO);
   wire logic we_sw = dp_wr_r && (dp_addr_r == ADDR_SW_CTRL);
   wire logic we_amux = dp_wr_r && (dp_addr_r == ADDR_AMUX);
   wire logic we_bbm = dp_wr_r && (dp_addr_r == ADDR_BBM);
   wire logic we_mode = dp_wr_r && (dp_addr_r == ADDR_MODE);
   wire logic [7:0] wbyte = hwdata[7:0];

   // [RQ1] low byte store
   assign ch3_lo_nxt = we_lo ? wbyte : ch3_lo_r;
   // [RQ2] upper code bits store
   assign ch3_hi_nxt = we_hi ? wbyte : ch3_hi_r;
   assign sw_ctrl_nxt = we_sw ? wbyte : sw_ctrl_r;
   // [RQ6] mux control store
   assign amux_nxt = we_amux ? wbyte : amux_r;
   assign bbm_nxt = we_bbm ? wbyte : bbm_r;
   assign mode_nxt = we_mode ? wbyte : mode_r;

   // read muxed from next values so a read right after a write sees it
   wire logic [7:0] rd_byte =
      (a_addr == ADDR_CH3_HI) ? ch3_hi_nxt :
      (a_addr == ADDR_CH3_LO) ? ch3_lo_nxt :
      (a_addr == ADDR_SW_CTRL) ? sw_ctrl_nxt :
      (a_addr == ADDR_AMUX) ? amux_nxt :
      (a_addr == ADDR_BBM) ? bbm_nxt :
      (a_addr == ADDR_MODE) ? mode_nxt : RST_BYTE;
   wire logic [31:0] hrdata_nxt = (take && !hwrite) ? {24'h00_0000, rd_byte} : hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= '0;
         hrdata_r <= WORD_ZERO;
         ch3_hi_r <= RST_BYTE;
         ch3_lo_r <= RST_BYTE;
         sw_ctrl_r <= RST_BYTE;
         amux_r <= RST_BYTE;
         bbm_r <= RST_BYTE;
         mode_r <= RST_BYTE;
      end else begin
         dp_wr_r <= take && hwrite;
         dp_addr_r <= a_addr;
         hrdata_r <= hrdata_nxt;
         ch3_hi_r <= ch3_hi_nxt;
         ch3_lo_r <= ch3_lo_nxt;
         sw_ctrl_r <= sw_ctrl_nxt;
         amux_r <= amux_nxt;
         bbm_r <= bbm_nxt;
         mode_r <= mode_nxt;
      end
   end

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // ---------------------------------------------
   // field outputs
   // ---------------------------------------------
   // [RQ3] full code range passed through
   assign channel3_current_code = {ch3_hi_r[1:0], ch3_lo_r};
   assign undervoltage_trim = sw_ctrl_r[SW_CTRL_TRIM_MSB:0];
   assign analog_mux_enable = amux_r[AMUX_EN_BIT];
   assign analog_calibration_disable = amux_r[AMUX_CAL_BIT];
   assign analog_gain_select = amux_r[AMUX_GAIN_MSB:AMUX_GAIN_LSB];
   assign analog_input_select = amux_r[AMUX_SEL_MSB:0];

   // ---------------------------------------------
   // switch sequencer
   // ---------------------------------------------
   lsbbm_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0] sel_r;
   logic [2:0] sw_r, sw_nxt;
   wire logic direct_en = mode_r[MODE_DIRECT_BIT];
   wire logic [2:0] direct_bits = sw_ctrl_r[7:SW_CTRL_SW_LSB];
   wire logic sel_chg = colour_channel_select != sel_r;
   wire logic [CNT_W-1:0] dead_cyc = dead_cycles(bbm_r);
   logic [2:0] seq_sw;

   // changes during break or dead time do not restart it; the newest select wins
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + CNT_ONE;
      seq_sw = sel_decode(sel_r);
      case (state_r)
         ST_RUN: begin
            cnt_nxt = CNT_ONE;
            seq_sw = sw_r;
            if (sel_chg) begin
               state_nxt = ST_BREAK;
            end
         end
         ST_BREAK: begin
            seq_sw = sw_r;
            // [RQ8] switches off after fixed turn-off delay
            if (cnt_r == CNT_OFF_LAST) begin
               seq_sw = 3'h0;
               cnt_nxt = CNT_ONE;
               state_nxt = (dead_cyc == '0) ? ST_RUN : ST_DEAD;
               if (dead_cyc == '0) begin
                  seq_sw = sel_decode(colour_channel_select);
               end
            end
         end
         ST_DEAD: begin
            seq_sw = 3'h0;
            // [RQ7] hold off for the coded dead time
            if (cnt_r >= dead_cyc) begin
               seq_sw = sel_decode(colour_channel_select);
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
            seq_sw = 3'h0;
         end
      endcase
   end

   // [RQ4] direct bits drive switches
   // [RQ5] stored bits ignored unless direct
   assign sw_nxt = direct_en ? direct_bits : seq_sw;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_RUN;
         cnt_r <= '0;
         sel_r <= 2'h0;
         sw_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sel_r <= colour_channel_select;
         sw_r <= sw_nxt;
      end
   end

   assign channel_switch_on = sw_r;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   property p_lo_write;
      @(posedge hclk) disable iff (!hresetn)
      we_lo |=> channel3_current_code[7:0] == $past(hwdata[7:0]);
   endproperty
   a_lo_write: assert property (p_lo_write) else $error("low code byte not stored"); // [RQ1]

   property p_hi_write;
      @(posedge hclk) disable iff (!hresetn)
      we_hi |=> channel3_current_code[9:8] == $past(hwdata[1:0]);
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("upper code bits not taken"); // [RQ2]

   property p_code_hold;
      @(posedge hclk) disable iff (!hresetn)
      (!we_lo && !we_hi) |=> $stable(channel3_current_code);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("current code changed without write"); // [RQ3]

   property p_direct;
      @(posedge hclk) disable iff (!hresetn)
      direct_en |=> channel_switch_on == $past(sw_ctrl_r[7:5]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct bits not on switches"); // [RQ4]

   property p_no_direct;
      @(posedge hclk) disable iff (!hresetn)
      (!direct_en && state_r == ST_RUN && !sel_chg && !$past(direct_en)) |=> $stable(channel_switch_on);
   endproperty
   a_no_direct: assert property (p_no_direct) else $error("switch moved without cause"); // [RQ5]

   property p_amux;
      @(posedge hclk) disable iff (!hresetn)
      we_amux |=> {analog_mux_enable, analog_calibration_disable, analog_gain_select,
                   analog_input_select} == $past(hwdata[7:0]);
   endproperty
   a_amux: assert property (p_amux) else $error("mux control fields wrong"); // [RQ6]

   property p_dead_len;
      @(posedge hclk) disable iff (!hresetn)
      (state_r == ST_DEAD && cnt_r == dead_cyc && !direct_en) |=>
         state_r == ST_RUN && channel_switch_on == sel_decode($past(colour_channel_select));
   endproperty
   a_dead_len: assert property (p_dead_len) else $error("dead time end wrong"); // [RQ7]

   property p_dead_off;
      @(posedge hclk) disable iff (!hresetn)
      (state_r == ST_DEAD && !direct_en && !$past(direct_en)) |-> channel_switch_on == 3'h0;
   endproperty
   a_dead_off: assert property (p_dead_off) else $error("switch on during dead time"); // [RQ7]

   property p_break;
      @(posedge hclk) disable iff (!hresetn)
      (sel_chg && state_r == ST_RUN && !direct_en) ##1 (!direct_en)[*7] |-> channel_switch_on == 3'h0
         || $past(state_r) == ST_BREAK && dead_cyc == '0;
   endproperty
   a_break: assert property (p_break) else $error("switches not off in time"); // [RQ8]

   // lower bound: a too-short break would slip past a_break alone
   property p_break_early;
      @(posedge hclk) disable iff (!hresetn)
      (sel_chg && state_r == ST_RUN && !direct_en) ##1 (!direct_en)[*6] |->
         channel_switch_on == $past(channel_switch_on, 6);
   endproperty
   a_break_early: assert property (p_break_early) else $error("switches moved before break time"); // [RQ8]

   property p_bbm_store;
      @(posedge hclk) disable iff (!hresetn)
      we_bbm |=> bbm_r == $past(hwdata[7:0]);
   endproperty
   a_bbm_store: assert property (p_bbm_store) else $error("dead time code not stored"); // [RQ7]

   property p_sw_store;
      @(posedge hclk) disable iff (!hresetn)
      we_sw |=> {direct_bits, undervoltage_trim} == $past(hwdata[7:0]);
   endproperty
   a_sw_store: assert property (p_sw_store) else $error("switch control byte not stored"); // [RQ5]

   c_sel_change: cover property (@(posedge hclk) disable iff (!hresetn) sel_chg && !direct_en);
   c_dead_done: cover property (@(posedge hclk) disable iff (!hresetn)
      state_r == ST_DEAD ##1 state_r == ST_RUN);
   c_direct: cover property (@(posedge hclk) disable iff (!hresetn) direct_en && we_sw);
   c_read: cover property (@(posedge hclk) disable iff (!hresetn) take && !hwrite);
   c_sel_off: cover property (@(posedge hclk) disable iff (!hresetn)
      state_r == ST_BREAK && colour_channel_select == 2'h0);

endmodule

`default_nettype wire

// file: lsbbm_pkg.sv
// constants and types for the led switch / analog mux / dead-time register slice
package lsbbm_pkg;
   // ---------------------------------------------
   // register indices and byte addresses
   // ---------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] IDX_CH3_HI = 12'h007;
   localparam logic [ADDR_W-1:0] IDX_CH3_LO = 12'h008;
   localparam logic [ADDR_W-1:0] IDX_SW_CTRL = 12'h009;
   localparam logic [ADDR_W-1:0] IDX_AMUX = 12'h00A;
   localparam logic [ADDR_W-1:0] IDX_BBM = 12'h00B;
   localparam logic [ADDR_W-1:0] IDX_MODE = 12'h011;
   localparam logic [ADDR_W-1:0] ADDR_CH3_HI = IDX_CH3_HI << 2;
   localparam logic [ADDR_W-1:0] ADDR_CH3_LO = IDX_CH3_LO << 2;
   localparam logic [ADDR_W-1:0] ADDR_SW_CTRL = IDX_SW_CTRL << 2;
   localparam logic [ADDR_W-1:0] ADDR_AMUX = IDX_AMUX << 2;
   localparam logic [ADDR_W-1:0] ADDR_BBM = IDX_BBM << 2;
   localparam logic [ADDR_W-1:0] ADDR_MODE = IDX_MODE << 2;
   // ---------------------------------------------
   // reset values and field positions
   // ---------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int SW_CTRL_SW_LSB = 5;
   localparam int SW_CTRL_TRIM_MSB = 4;
   localparam int AMUX_EN_BIT = 7;
   localparam int AMUX_CAL_BIT = 6;
   localparam int AMUX_GAIN_MSB = 5;
   localparam int AMUX_GAIN_LSB = 4;
   localparam int AMUX_SEL_MSB = 3;
   localparam int MODE_DIRECT_BIT = 0;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SW_OFF_MIN_NS = 333;
   localparam int SW_OFF_MAX_NS = 444;
   localparam int SW_OFF_CYC = (SW_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_OFF_MAX_CYC = SW_OFF_MAX_NS / CLK_PERIOD_NS;
   localparam int BBM_FIRST_NS = 333;
   localparam int BBM_STEP_NS = 111;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
   localparam logic [CNT_W-1:0] CNT_OFF_LAST = CNT_W'(SW_OFF_CYC - 1);
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_BREAK = 2'b01,
      ST_DEAD = 2'b10
   } lsbbm_state_t;
endpackage

// file: led_switch_afe_bbm_regs_test.sv
// self-checking bench for the led switch / mux / dead-time register slice
`timescale 1ns/1ps
`default_nettype none
module led_switch_afe_bbm_regs_test import lsbbm_pkg::*; ;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, colour_channel_select, analog_gain_select;
   logic [2:0] hsize, channel_switch_on;
   logic [9:0] channel3_current_code;
   logic [4:0] undervoltage_trim;
   logic analog_mux_enable, analog_calibration_disable;
   logic [3:0] analog_input_select;
   logic [31:0] rdv;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   // ---------------------------------------------
   // design and clock
   // ---------------------------------------------
   assign hready = hreadyout;
   lsbbm_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .colour_channel_select(colour_channel_select),
      .channel3_current_code(channel3_current_code), .channel_switch_on(channel_switch_on),
      .undervoltage_trim(undervoltage_trim), .analog_mux_enable(analog_mux_enable),
      .analog_calibration_disable(analog_calibration_disable),
      .analog_gain_select(analog_gain_select), .analog_input_select(analog_input_select));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // hang guard: longest dead time is under 600 cycles, whole run far below this
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic end_sim();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= 1'b0;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      rd(a, rdv);
      chk(rdv, {24'h000000, e});
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_code(input logic [7:0] hi, input logic [7:0] lo, input logic [9:0] e);
      wr(ADDR_CH3_HI, hi);
      wr(ADDR_CH3_LO, lo);
      rdchk(ADDR_CH3_HI, hi);
      rdchk(ADDR_CH3_LO, lo);
      chk({22'h000000, channel3_current_code}, {22'h000000, e});
   endtask
   task automatic t_mux(input logic [7:0] v);
      wr(ADDR_AMUX, v);
      rdchk(ADDR_AMUX, v);
      chk({24'h000000, analog_mux_enable, analog_calibration_disable, analog_gain_select,
         analog_input_select}, {24'h000000, v});
   endtask
   // turn-off window then dead time before the newly selected switch closes
   task automatic t_bbm(input logic [7:0] code, input logic [1:0] sel);
      int n;
      int dead;
      logic [2:0] old;
      logic [2:0] want;
      n = 0;
      want = (sel == 2'h0) ? 3'h0 : 3'(1 << (sel - 1));
      dead = (code == 8'h00) ? 0 : (BBM_FIRST_NS + BBM_STEP_NS * (code - 1) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      wr(ADDR_BBM, code);
      rdchk(ADDR_BBM, code);
      @(posedge hclk);
      old = channel_switch_on;
      colour_channel_select <= sel;
      do begin
         @(posedge hclk);
         #1;
         n++;
      end while (channel_switch_on === old && n < 50);
      chk(32'(n >= SW_OFF_CYC && n <= SW_OFF_MAX_CYC), 32'h1);
      if (dead > 0) begin
         chk({29'h0, channel_switch_on}, 32'h0);
      end
      n = 0;
      while (channel_switch_on !== want && n < 700) begin
         @(posedge hclk);
         #1;
         n++;
      end
      chk(32'(n), 32'(dead));
   endtask
   task automatic t_direct();
      wr(ADDR_SW_CTRL, 8'hC3);
      repeat (3) @(posedge hclk);
      #1;
      // stored but not applied while direct control is off
      chk({29'h0, channel_switch_on}, 32'h1);
      chk({27'h0, undervoltage_trim}, 32'h3);
      rdchk(ADDR_SW_CTRL, 8'hC3);
      wr(ADDR_MODE, 8'h01);
      repeat (2) @(posedge hclk);
      #1;
      chk({29'h0, channel_switch_on}, 32'h6);
      @(posedge hclk);
      colour_channel_select <= 2'h3;
      repeat (30) @(posedge hclk);
      #1;
      chk({29'h0, channel_switch_on}, 32'h6);
      wr(ADDR_SW_CTRL, 8'h20);
      repeat (2) @(posedge hclk);
      #1;
      chk({29'h0, channel_switch_on}, 32'h1);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      colour_channel_select = 2'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(ADDR_CH3_LO, 8'h00);
      rdchk(ADDR_AMUX, 8'h00);
      rdchk(ADDR_BBM, 8'h00);
      chk({22'h0, channel3_current_code}, 32'h0);
      t_code(8'hFE, 8'h5A, 10'h25A);
      t_code(8'h03, 8'hFF, 10'h3FF);
      t_code(8'h00, 8'h00, 10'h000);
      t_mux(8'hB6);
      t_mux(8'h49);
      wr(12'h100, 8'hFF);
      rdchk(12'h100, 8'h00);
      t_bbm(8'h00, 2'h1);
      t_bbm(8'h01, 2'h2);
      t_bbm(8'h02, 2'h3);
      t_bbm(8'hFF, 2'h2);
      t_bbm(8'h00, 2'h0);
      t_bbm(8'h00, 2'h1);
      t_direct();
      end_sim();
   end
endmodule
`default_nettype wire
